// [hw/tpo_link_if.sv]
// Link between the timer end and the pattern output unit.
// Assumes both ends share i_clk; every signal is driven from a flip-flop.
interface tpo_link_if;
   logic [3:0] match_a;       // Compare match A pulse per channel
   logic [3:0] match_b;       // Compare match B pulse per channel
   logic [3:0] capture_a;     // Input capture A pulse per channel
   logic [3:0] gra_capture;   // Level: general_reg_a works as capture
   logic [15:0] tmr_pin_en;   // Level: timer owns the pin
   logic [15:0] tmr_pin_val;  // Timer output level for owned pins

   modport device_end (
      input match_a, match_b, capture_a, gra_capture, tmr_pin_en, tmr_pin_val
   );
   modport timer_end (
      output match_a, match_b, capture_a, gra_capture, tmr_pin_en, tmr_pin_val
   );
endinterface

// [hw/tpo_pattern_unit.sv]
// Pattern output unit: next-data to port data transfer on timer events.
// Assumes the timer end drives the link on the same clock; pins are async.
module tpo_pattern_unit #(
   parameter int PATTERN_W = tpo_pkg::PATTERN_W  // Pattern bits
) (
   input wire logic i_clk,                          // System clock
   input wire logic i_sys_rst,                      // Async reset, active high
   input wire logic i_hw_standby,                   // Hardware standby level
   input wire logic i_mode_wr,                      // output_mode_select write
   input wire logic [7:0] i_mode_wdata,             // Mode write data
   input wire logic i_trig_wr,                      // trigger_select_reg write
   input wire logic [7:0] i_trig_wdata,             // Trigger write data
   input wire logic i_data_wr,                      // Port data write strobe
   input wire logic [PATTERN_W-1:0] i_data_wdata,   // Port data write value
   input wire logic [PATTERN_W-1:0] i_next_pattern, // next_pattern bits
   input wire logic [PATTERN_W-1:0] i_pattern_enable, // pattern_enable_bit
   input wire logic [PATTERN_W-1:0] i_direction,    // Direction, 1 = out
   input wire logic [PATTERN_W-1:0] i_pin_in,       // Pin levels, async
   output logic [7:0] o_mode_rd,                    // Mode readback
   output logic [7:0] o_trig_rd,                    // Trigger select readback
   output logic [PATTERN_W-1:0] o_port_rd,          // Port read value
   output logic [PATTERN_W-1:0] o_pulse_mode,       // Bit acts as pulse output
   output logic [PATTERN_W-1:0] o_pin_out,          // pattern_pin level
   output logic [PATTERN_W-1:0] o_pin_oe,           // pattern_pin drive enable
   tpo_link_if.device_end link                      // Events from timer end
);
   logic [7:0] mode_q;
   logic [7:0] trig_q;
   logic [PATTERN_W-1:0] data_q;
   logic [PATTERN_W-1:0] pin_s1_q;
   logic [PATTERN_W-1:0] pin_s2_q;
   logic [7:0] mode_rd_q;
   logic [7:0] trig_rd_q;
   logic [PATTERN_W-1:0] port_rd_q;
   logic [PATTERN_W-1:0] pulse_q;
   logic [PATTERN_W-1:0] pin_out_q;
   logic [PATTERN_W-1:0] pin_oe_q;

   wire [3:0] event_a;
   wire [3:0] grp_hit_a;
   wire [3:0] grp_hit_b;
   wire [PATTERN_W-1:0] xfer_mask;
   wire [PATTERN_W-1:0] wr_mask;
   wire [PATTERN_W-1:0] data_after_wr;
   wire [PATTERN_W-1:0] data_d;
   wire [PATTERN_W-1:0] read_only;
   wire [PATTERN_W-1:0] drive_en;
   wire [PATTERN_W-1:0] drive_val;
   wire [7:0] mode_d;
   wire [7:0] trig_d;
   wire [PATTERN_W-1:0] timer_val;
   wire [PATTERN_W-1:0] latch_val;
   wire [7:0] mode_rd_d;
   wire [PATTERN_W-1:0] port_rd_d;
   wire [PATTERN_W-1:0] pulse_d;
   wire [PATTERN_W-1:0] pin_out_d;

   // A capturing channel triggers on its capture, not on match A
   assign event_a = (link.gra_capture & link.capture_a)
                  | (~link.gra_capture & link.match_a);

   // Each group decodes its own channel and mode
   for (genvar g = 0; g < tpo_pkg::GROUPS; g++) begin : g_grp
      wire [tpo_pkg::SEL_W-1:0] sel;
      wire nonoverlap;
      wire [tpo_pkg::GROUP_W-1:0] nxt;
      wire [tpo_pkg::GROUP_W-1:0] en;

      assign sel = trig_q[g*tpo_pkg::SEL_W +: tpo_pkg::SEL_W];
      assign nonoverlap = mode_q[g];
      assign nxt = i_next_pattern[g*tpo_pkg::GROUP_W +: tpo_pkg::GROUP_W];
      assign en = i_pattern_enable[g*tpo_pkg::GROUP_W +: tpo_pkg::GROUP_W];

      assign grp_hit_a[g] = tpo_pkg::pick_channel(event_a, sel);
      // Match B only counts in non-overlap mode
      assign grp_hit_b[g] = nonoverlap
                          & tpo_pkg::pick_channel(link.match_b, sel);

      // Match A copies every enabled bit; match B only lets zeros through
      assign xfer_mask[g*tpo_pkg::GROUP_W +: tpo_pkg::GROUP_W] =
         en & ({tpo_pkg::GROUP_W{grp_hit_a[g]}}
             | ({tpo_pkg::GROUP_W{grp_hit_b[g]}} & ~nxt));
   end

   // Enabled input bits refuse software writes
   assign read_only = i_pattern_enable & ~i_direction;
   assign wr_mask = {PATTERN_W{i_data_wr}} & ~read_only;
   assign data_after_wr = (data_q & ~wr_mask) | (i_data_wdata & wr_mask);
   // A transfer in the same cycle as a write wins on the bits it moves
   assign data_d = (data_after_wr & ~xfer_mask)
                 | (i_next_pattern & xfer_mask);

   assign mode_d = (i_mode_wdata & ~tpo_pkg::MODE_RSVD_MASK)
                 | tpo_pkg::MODE_RSVD_MASK;
   assign trig_d = i_trig_wdata;

   // Timer-owned pins show the timer level; data still moves underneath
   assign drive_en = (i_direction | link.tmr_pin_en)
                   & tpo_pkg::PIN_MASK[PATTERN_W-1:0];
   assign timer_val = link.tmr_pin_en & link.tmr_pin_val;
   assign latch_val = ~link.tmr_pin_en & data_q;
   assign drive_val = timer_val | latch_val;

   assign o_mode_rd = mode_rd_q;
   assign o_trig_rd = trig_rd_q;
   assign o_port_rd = port_rd_q;
   assign o_pulse_mode = pulse_q;
   assign o_pin_out = pin_out_q;
   assign o_pin_oe = pin_oe_q;

   // Next values of the output flops; every output leaves a flop
   assign mode_rd_d = mode_q | tpo_pkg::MODE_RSVD_MASK;
   // Output bits read back the latch, input bits the pin
   assign port_rd_d = (i_direction & data_q) | (~i_direction & pin_s2_q);
   assign pulse_d = i_pattern_enable & i_direction;
   assign pin_out_d = drive_val & tpo_pkg::PIN_MASK[PATTERN_W-1:0];

   // Hardware standby reinitialises; software standby is not seen here
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mode_q <= tpo_pkg::MODE_RESET;
      end else if (i_hw_standby) begin
         mode_q <= tpo_pkg::MODE_RESET;
      end else if (i_mode_wr) begin
         mode_q <= mode_d;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         trig_q <= tpo_pkg::TRIG_RESET;
      end else if (i_hw_standby) begin
         trig_q <= tpo_pkg::TRIG_RESET;
      end else if (i_trig_wr) begin
         trig_q <= trig_d;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         data_q <= '0;
      end else begin
         data_q <= data_d;
      end
   end

   // Pin inputs cross in through two flops
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pin_s1_q <= '0;
      end else begin
         pin_s1_q <= i_pin_in;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pin_s2_q <= '0;
      end else begin
         pin_s2_q <= pin_s1_q;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mode_rd_q <= tpo_pkg::MODE_RESET;
      end else begin
         mode_rd_q <= mode_rd_d;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         trig_rd_q <= tpo_pkg::TRIG_RESET;
      end else begin
         trig_rd_q <= trig_q;
      end
   end

   // Input bits read the pin three clocks late
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         port_rd_q <= '0;
      end else begin
         port_rd_q <= port_rd_d;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pulse_q <= '0;
      end else begin
         pulse_q <= pulse_d;
      end
   end

   // Owned pins follow the timer one clock after the link
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pin_out_q <= '0;
      end else begin
         pin_out_q <= pin_out_d;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pin_oe_q <= '0;
      end else begin
         pin_oe_q <= drive_en;
      end
   end
endmodule // tpo_pattern_unit

// [hw/tpo_pkg.sv]
// What this block does
// - Group 0 trigger select in bits 1:0
// - Mode register resets to f0, standby too
// - Mode bits 7:4 read one, ignore writes
// - Mode bits 3:0 select non-overlap per group
// - Normal mode: update only at match A
// - Non-overlap mode uses match A and B
// - Software: period in B, margin in A
// - Pulse output needs direction and enable set
// - Selected event copies enabled next-data bits
// - Enabled input bit: read-only, still loaded
// - Software writes next data before next match
// - Pattern bit 14 never drives a pin
// - Software: match A clears counter, period
// - Match A handler writes next pattern
// - Trigger select resets ff, 2-bit fields
// - Non-overlap: match B copies only zeros
// - Capture event replaces match A when capturing
// - Transfers continue when timer owns pin
//
// Shared constants for the timed pattern output unit and its timer end.
// Assumes both ends run on one clock and reset together.
package tpo_pkg;
   localparam int PATTERN_W = 16;
   localparam int GROUP_W = 4;
   localparam int GROUPS = 4;
   localparam int CHANNELS = 4;
   localparam int SEL_W = 2;
   localparam int NO_PIN_BIT = 14;
   localparam int TIMER_W = 16;
   localparam logic [7:0] MODE_RESET = 8'hf0;
   localparam logic [7:0] MODE_RSVD_MASK = 8'hf0;
   localparam logic [7:0] TRIG_RESET = 8'hff;
   localparam logic [15:0] PIN_MASK = 16'hbfff;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [3:0] ZERO4 = 4'h0;
   localparam logic [15:0] TIMER_ZERO = 16'h0000;
   localparam logic [15:0] TIMER_ONE = 16'h0001;

   // One event bit of the channel that a group selects
   function automatic logic pick_channel(input logic [CHANNELS-1:0] ev,
                                         input logic [SEL_W-1:0] sel);
      pick_channel = ev[sel];
   endfunction
endpackage

// [hw/tpo_timer_end.sv]
// Timer end: four channels that supply match and capture events.
// Assumes software configures channels through the plain write port.
module tpo_timer_end (
   input wire logic i_clk,                  // System clock
   input wire logic i_sys_rst,              // Async reset, active high
   input wire logic i_cfg_wr,               // Channel config write strobe
   input wire logic [1:0] i_cfg_ch,         // Channel being configured
   input wire logic [15:0] i_cfg_gra,       // general_reg_a value
   input wire logic [15:0] i_cfg_grb,       // general_reg_b value
   input wire logic i_cfg_clr_on_b,         // Clear counter at match B
   input wire logic i_cfg_capture,          // general_reg_a as input capture
   input wire logic i_cfg_run,              // Counter runs
   input wire logic [3:0] i_capture_pin,    // Capture pins, async
   input wire logic [3:0] i_flag_clr,       // Clear match_a_flag bits
   input wire logic [15:0] i_tmr_pin_en,    // Timer takes pattern pins
   input wire logic [15:0] i_tmr_pin_val,   // Timer levels for those pins
   output logic [3:0] o_match_a_flag,       // Sticky match A / capture flags
   tpo_link_if.timer_end link               // Link to pattern unit
);
   logic [15:0] cnt_q [4];
   logic [15:0] gra_q [4];
   logic [15:0] grb_q [4];
   logic [3:0] clr_b_q;
   logic [3:0] capt_q;
   logic [3:0] run_q;
   logic [3:0] cap_s1_q;
   logic [3:0] cap_s2_q;
   logic [3:0] cap_s3_q;
   logic [3:0] hit_a;
   logic [3:0] hit_b;
   logic [3:0] cap_edge;
   logic [3:0] flag_q;

   assign cap_edge = cap_s2_q & ~cap_s3_q & capt_q & run_q;
   assign o_match_a_flag = flag_q;

   for (genvar c = 0; c < 4; c++) begin : g_ch
      assign hit_a[c] = run_q[c] & ~capt_q[c] & (cnt_q[c] == gra_q[c]);
      assign hit_b[c] = run_q[c] & (cnt_q[c] == grb_q[c]);

      always_ff @(posedge i_clk or posedge i_sys_rst) begin
         if (i_sys_rst) begin
            cnt_q[c] <= tpo_pkg::TIMER_ZERO;
            gra_q[c] <= tpo_pkg::TIMER_ZERO;
            grb_q[c] <= tpo_pkg::TIMER_ZERO;
         end else if (i_cfg_wr && i_cfg_ch == 2'(c)) begin
            cnt_q[c] <= tpo_pkg::TIMER_ZERO;
            gra_q[c] <= i_cfg_gra;
            grb_q[c] <= i_cfg_grb;
         end else begin
            // Period in B with margin in A, or period in A
            if ((clr_b_q[c] && hit_b[c]) || (!clr_b_q[c] && hit_a[c])) begin
               cnt_q[c] <= tpo_pkg::TIMER_ZERO;
            end else if (run_q[c]) begin
               cnt_q[c] <= cnt_q[c] + tpo_pkg::TIMER_ONE;
            end
            if (cap_edge[c]) begin
               gra_q[c] <= cnt_q[c];
            end
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         clr_b_q <= tpo_pkg::ZERO4;
         capt_q <= tpo_pkg::ZERO4;
         run_q <= tpo_pkg::ZERO4;
      end else if (i_cfg_wr) begin
         clr_b_q[i_cfg_ch] <= i_cfg_clr_on_b;
         capt_q[i_cfg_ch] <= i_cfg_capture;
         run_q[i_cfg_ch] <= i_cfg_run;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cap_s1_q <= tpo_pkg::ZERO4;
         cap_s2_q <= tpo_pkg::ZERO4;
         cap_s3_q <= tpo_pkg::ZERO4;
         flag_q <= tpo_pkg::ZERO4;
      end else begin
         cap_s1_q <= i_capture_pin;
         cap_s2_q <= cap_s1_q;
         cap_s3_q <= cap_s2_q;
         // Set beats clear so no match is lost to the handler
         flag_q <= (flag_q & ~i_flag_clr) | hit_a | cap_edge;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         link.match_a <= tpo_pkg::ZERO4;
         link.match_b <= tpo_pkg::ZERO4;
         link.capture_a <= tpo_pkg::ZERO4;
         link.gra_capture <= tpo_pkg::ZERO4;
         link.tmr_pin_en <= tpo_pkg::ZERO16;
         link.tmr_pin_val <= tpo_pkg::ZERO16;
      end else begin
         link.match_a <= hit_a;
         link.match_b <= hit_b;
         link.capture_a <= cap_edge;
         link.gra_capture <= capt_q;
         link.tmr_pin_en <= i_tmr_pin_en;
         link.tmr_pin_val <= i_tmr_pin_val;
      end
   end
endmodule // tpo_timer_end

// [tb/timed_pattern_output_tb_top.sv]
// Bench: the timer end triggers the pattern unit over the link.
// Assumes one 4 ns clock; inputs move 1 ns after each rising edge.
module timed_pattern_output_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst, stby, mode_wr, trig_wr, data_wr, cfg_wr, clr_b, cap, run;
   logic [7:0] mode_wd, trig_wd, mode_rd, trig_rd;
   logic [1:0] cfg_ch;
   logic [3:0] cap_pin, fclr, flag;
   logic [15:0] data_wd, nxt, en, dir, pin_in, general_reg_a, general_reg_b, tpe, tpv;
   logic [15:0] port_rd, pulse, pin_out, pin_oe, exp;
   int error_cnt = 0;
   int comparisons = 0;
   tpo_link_if link ();
   tpo_timer_end tpo_timer_end_i (.i_clk(clk), .i_sys_rst(rst), .i_cfg_wr(cfg_wr),
      .i_cfg_ch(cfg_ch), .i_cfg_gra(general_reg_a), .i_cfg_grb(general_reg_b), .i_cfg_clr_on_b(clr_b),
      .i_cfg_capture(cap), .i_cfg_run(run), .i_capture_pin(cap_pin), .i_flag_clr(fclr),
      .i_tmr_pin_en(tpe), .i_tmr_pin_val(tpv), .o_match_a_flag(flag), .link(link));
   tpo_pattern_unit tpo_pattern_unit_i (.i_clk(clk), .i_sys_rst(rst), .i_hw_standby(stby),
      .i_mode_wr(mode_wr), .i_mode_wdata(mode_wd), .i_trig_wr(trig_wr), .i_trig_wdata(trig_wd),
      .i_data_wr(data_wr), .i_data_wdata(data_wd), .i_next_pattern(nxt),
      .i_pattern_enable(en), .i_direction(dir), .i_pin_in(pin_in), .o_mode_rd(mode_rd),
      .o_trig_rd(trig_rd), .o_port_rd(port_rd), .o_pulse_mode(pulse), .o_pin_out(pin_out),
      .o_pin_oe(pin_oe), .link(link));
   tpo_link_checker tpo_link_checker_i (.i_clk(clk), .i_sys_rst(rst), .i_hw_standby(stby),
      .i_mode_wr(mode_wr), .i_mode_wdata(mode_wd), .i_data_wr(data_wr), .i_direction(dir),
      .i_pattern_enable(en), .i_match_a(link.match_a), .i_match_b(link.match_b),
      .i_capture_a(link.capture_a), .i_tmr_pin_en(link.tmr_pin_en), .i_mode_rd(mode_rd),
      .i_trig_rd(trig_rd), .i_pulse_mode(pulse), .i_pin_out(pin_out), .i_pin_oe(pin_oe));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Kind 0 mode, 1 trigger, 2 port data
   task automatic wr(input int k, input logic [15:0] v);
      mode_wd = v[7:0];
      trig_wd = v[7:0];
      data_wd = v;
      mode_wr = (k == 0);
      trig_wr = (k == 1);
      data_wr = (k == 2);
      tick(1);
      {mode_wr, trig_wr, data_wr} = 3'b000;
      tick(2);
   endtask
   // One event on a channel, then the channel is stopped so no repeat lands
   task automatic fire(input logic [1:0] ch, input logic use_b, input logic use_cap);
      int n;
      logic hit;
      cfg_ch = ch;
      cap = use_cap;
      clr_b = use_b;
      general_reg_a = use_b ? 16'h0064 : 16'h0008;
      general_reg_b = use_b ? 16'h0008 : 16'h0064;
      // Capture edges only count while the counter runs
      run = 1'b1;
      cfg_wr = 1'b1;
      tick(1);
      cfg_wr = 1'b0;
      cap_pin[ch] = use_cap;
      for (n = 0; n < 200; n++) begin
         hit = use_b ? link.match_b[ch] : (use_cap ? link.capture_a[ch] : link.match_a[ch]);
         if (hit === 1'b1) break;
         tick(1);
      end
      chk("event seen", 16'h0001, {15'h0000, n < 200});
      chk("match a flag", {12'h000, (use_b ? 4'h0 : (4'h1 << ch))}, {12'h000, flag});
      run = 1'b0;
      cap = 1'b0;
      cfg_wr = 1'b1;
      tick(1);
      cfg_wr = 1'b0;
      cap_pin = 4'h0;
      fclr = 4'hf;
      tick(1);
      fclr = 4'h0;
      tick(3);
      chk("flag clear", 16'h0000, {12'h000, flag});
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      close_out();
   end
   initial begin
      {rst, stby, mode_wr, trig_wr, data_wr, cfg_wr, clr_b, cap, run} = 9'h100;
      {mode_wd, trig_wd, cfg_ch, cap_pin, fclr} = 26'h000_0000;
      {data_wd, nxt, en, dir, pin_in, general_reg_a, general_reg_b, tpe, tpv} = 144'h0;
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      tick(1);
      chk("mode reset", 16'h00f0, {8'h00, mode_rd});
      chk("trig reset", 16'h00ff, {8'h00, trig_rd});
      wr(0, 16'h00a5);
      chk("mode rd", 16'h00f5, {8'h00, mode_rd});
      wr(1, 16'h00e4);
      chk("trig rd", 16'h00e4, {8'h00, trig_rd});
      stby = 1'b1;
      wr(0, 16'h000f);
      stby = 1'b0;
      chk("mode stby", 16'h00f0, {8'h00, mode_rd});
      chk("trig stby", 16'h00ff, {8'h00, trig_rd});
      wr(0, 16'h0000);
      wr(1, 16'h00e4);
      $display("test registers done");
      {en, dir, nxt, exp} = {16'hffff, 16'hffff, 16'h7c3a, 16'h0000};
      for (int c = 0; c < 4; c++) begin
         fire(c[1:0], 1'b0, 1'b0);
         exp = exp | (nxt & (16'h000f << (4 * c)));
         chk("normal pins", exp & tpo_pkg::PIN_MASK, pin_out);
      end
      chk("pin enables", 16'hbfff, pin_oe);
      nxt = 16'h0000;
      fire(2'd0, 1'b1, 1'b0);
      chk("match b ignored", 16'h3c3a, pin_out);
      $display("test normal done");
      {en, nxt} = {16'h0000, 16'hffff};
      fire(2'd1, 1'b0, 1'b0);
      chk("disabled bits", 16'h3c3a, pin_out);
      wr(2, 16'h1234);
      chk("plain output", 16'h1234, pin_out);
      {en, dir, pin_in} = {16'h000f, 16'hfff0, 16'h0005};
      wr(2, 16'hffff);
      chk("input read", 16'hfff5, port_rd);
      dir = 16'hffff;
      tick(2);
      chk("read only", 16'hfff4, port_rd);
      {dir, nxt} = {16'hfff0, 16'h0009};
      fire(2'd0, 1'b0, 1'b0);
      dir = 16'hffff;
      tick(2);
      chk("input loaded", 16'hfff9, port_rd);
      $display("test ports done");
      en = 16'hffff;
      wr(0, 16'h0001);
      nxt = 16'h0005;
      fire(2'd0, 1'b1, 1'b0);
      chk("nov at b", 16'h0001, {12'h000, pin_out[3:0]});
      fire(2'd0, 1'b0, 1'b0);
      chk("nov at a", 16'h0005, {12'h000, pin_out[3:0]});
      nxt = 16'h0a05;
      fire(2'd2, 1'b0, 1'b1);
      chk("capture", 16'h000a, {12'h000, pin_out[11:8]});
      $display("test nov capture done");
      {tpe, tpv, nxt} = {16'h00f0, 16'h0000, 16'h0ab5};
      fire(2'd1, 1'b0, 1'b0);
      chk("timer owned", 16'h0005, {8'h00, pin_out[7:0]});
      tpe = 16'h0000;
      tick(3);
      chk("owned loaded", 16'h00b5, {8'h00, pin_out[7:0]});
      $display("test timer pins done");
      close_out();
   end
endmodule // timed_pattern_output_tb_top

// [tb/tpo_link_checker.sv]
// Checker on the link and the pattern unit outputs.
// Assumes one clock domain; the bench wires every input by name.
module tpo_link_checker (
   input wire logic i_clk,                   // Clock
   input wire logic i_sys_rst,               // Reset
   input wire logic i_hw_standby,            // Standby
   input wire logic i_mode_wr,               // Mode write
   input wire logic [7:0] i_mode_wdata,      // Mode data
   input wire logic i_data_wr,               // Data write
   input wire logic [15:0] i_direction,      // Direction
   input wire logic [15:0] i_pattern_enable, // Enables
   input wire logic [3:0] i_match_a,         // Match A
   input wire logic [3:0] i_match_b,         // Match B
   input wire logic [3:0] i_capture_a,       // Capture A
   input wire logic [15:0] i_tmr_pin_en,     // Timer owns pin
   input wire logic [7:0] i_mode_rd,         // Mode readback
   input wire logic [7:0] i_trig_rd,         // Trigger readback
   input wire logic [15:0] i_pulse_mode,     // Pulse mode
   input wire logic [15:0] i_pin_out,        // Pin level
   input wire logic [15:0] i_pin_oe          // Pin enable
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   property p_rsvd;
      i_mode_rd[7:4] == 4'hf;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("mode high bits not one");
   property p_pin14;
      !i_pin_out[14] && !i_pin_oe[14];
   endproperty
   a_pin14: assert property (p_pin14) else $error("bit 14 reached a pin");
   property p_mode_wr;
      (i_mode_wr && !i_hw_standby) ##1 (!i_mode_wr && !i_hw_standby) |->
         ##1 i_mode_rd == ($past(i_mode_wdata, 2) | tpo_pkg::MODE_RSVD_MASK);
   endproperty
   a_mode_wr: assert property (p_mode_wr) else $error("mode readback wrong");
   property p_standby;
      i_hw_standby [*2] |-> ##1 (i_mode_rd == 8'hf0 && i_trig_rd == 8'hff);
   endproperty
   a_standby: assert property (p_standby) else $error("standby did not reset");
   property p_pulse;
      i_pulse_mode == ($past(i_pattern_enable) & $past(i_direction));
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse mode wrong");
   // Normal mode group 0: match B or nothing must leave the pins alone
   sequence s_calm;
      i_tmr_pin_en == 16'h0000 && i_direction[3:0] == 4'hf;
   endsequence
   property p_norm;
      (s_calm and (!i_mode_rd[0] && i_match_a == 4'h0 && i_capture_a == 4'h0 && !i_data_wr))
         ##1 s_calm [*2] |-> $stable(i_pin_out[3:0]);
   endproperty
   a_norm: assert property (p_norm) else $error("normal group moved off match A");
   property p_oe_in;
      (i_direction[3:0] == 4'h0 && i_tmr_pin_en[3:0] == 4'h0) [*3] |-> i_pin_oe[3:0] == 4'h0;
   endproperty
   a_oe_in: assert property (p_oe_in) else $error("input pin driven");
   property p_oe_out;
      (i_direction[0] && !i_tmr_pin_en[0]) [*3] |-> i_pin_oe[0];
   endproperty
   a_oe_out: assert property (p_oe_out) else $error("output pin not driven");
   property p_oe_tmr;
      i_tmr_pin_en[4] [*3] |-> i_pin_oe[4];
   endproperty
   a_oe_tmr: assert property (p_oe_tmr) else $error("timer pin not driven");
   c_match_b: cover property (i_match_b != 4'h0);
   c_capture: cover property (i_capture_a != 4'h0);
   c_own: cover property (i_tmr_pin_en != 16'h0000);
endmodule // tpo_link_checker
